/* hdl/serial_switch_spi.sv */
// Serial control and fault status interface of a 16-output low-side switch
// Summary of operation
// - Sample serial input on falling clock, selected
// - Drive next status bit on rising clock
// - Shift register holds exactly 24 bits
// - Chip select rise latches command word
// - Chip select fall loads fault status
// - Serial output driven only while selected
// - Deselected: ignore clock and input
// - Status: any, overvoltage, six zeros, outputs
// - Both words most significant bit first
// - Status one means fault
// - Control zero off, one on
// - Fault sets after persisting 100 to 450 us
// - Outputs switch 1 to 50 us after latch
// - Serial clock up to 6 MHz
// - Daisy chain: 24 bits per device
// - Command from bits 23:18, settings 15:0
// - Reset pin clears registers, outputs off
`timescale 1ns/1ps
`include "serial_switch_defs.svh"

module serial_switch_spi #(
    parameter int WORD_W = `WORD_W,
    parameter int N_OUT  = `N_OUT
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Device pins from the master
    input  wire logic             rst_pin_n,
    input  wire logic             cs_n,
    input  wire logic             sclk,
    input  wire logic             si,
    // Serial output pin
    output logic                  so_o,
    output logic                  so_oe,
    // Output stage
    output logic [N_OUT-1:0]      out_on,
    output logic [N_OUT-1:0]      open_cur_en,
    input  wire logic [N_OUT-1:0] short_raw,
    input  wire logic [N_OUT-1:0] open_raw,
    input  wire logic             ov_raw,
    // Latched command word for the command decoders outside this block
    output logic [WORD_W-1:0]     cmd_word,
    output logic                  cmd_strobe
);

    logic [3:0]        p1_q;
    logic [3:0]        p2_q;
    logic [3:0]        p3_q;
    logic [3:0]        pin_q;
    logic [3:0]        pin_d;
    logic [3:0]        prev_q;
    logic              clr;
    logic              cs_fall;
    logic              cs_rise;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              sel;
    logic [WORD_W-1:0] sr_q;
    logic [WORD_W-1:0] status;
    logic [N_OUT-1:0]  ctrl_q;
    logic [N_OUT-1:0]  fault;
    logic [N_OUT-1:0]  pend_q;
    logic [5:0]        cmd;
    logic              is_on_off;
    logic              is_open_en;
    logic              is_soft_rst;
    logic              ov_fault;
    logic [5:0]        wait_q;
    serial_switch_pkg::latch_state_e st_q;

    generate
        if (WORD_W != 24 || N_OUT != 16) begin : g_chk
            $error("serial_switch_spi: word must be 24 bits over 16 outputs");
        end
    endgenerate

    // Three-stage synchronisers for {rst_pin_n, cs_n, sclk, si}; each link level needs two clk
    always_ff @(posedge clk) begin
        p1_q <= {rst_pin_n, cs_n, sclk, si};
        p2_q <= p1_q;
        p3_q <= p2_q;
    end

    assign pin_d = (p2_q & ~(p2_q ^ p3_q)) | (pin_q & (p2_q ^ p3_q));

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_q  <= `PIN_IDLE;
            prev_q <= `PIN_IDLE;
        end else begin
            pin_q  <= pin_d;
            prev_q <= pin_q;
        end
    end

    // Edge detection on stabilised pins; clock edges only count while selected
    assign clr       = reset || !pin_q[3];
    assign sel       = !pin_q[2] && !prev_q[2];
    assign cs_fall   = !pin_q[2] && prev_q[2];
    assign cs_rise   = pin_q[2] && !prev_q[2];
    assign sclk_rise = sel && pin_q[1] && !prev_q[1];
    assign sclk_fall = sel && !pin_q[1] && prev_q[1];

    // Status word layout, one means fault
    assign status = {|fault || ov_fault, ov_fault, 6'h00, fault};

    // Shared shift register: status out at the top, serial input in at the bottom
    always_ff @(posedge clk) begin
        if (clr) begin
            sr_q <= '0;
        end else if (cs_fall) begin
            sr_q <= status;
        end else if (sclk_fall) begin
            sr_q <= {sr_q[WORD_W-2:0], pin_q[0]};
        end
    end

    // Serial output register updates on rising clock edges
    always_ff @(posedge clk) begin
        if (clr || cs_fall) begin
            so_o <= 1'b0;
        end else if (sclk_rise) begin
            so_o <= sr_q[WORD_W-1];
        end
    end

    assign so_oe = !clr && !pin_q[2];

    // Command decode of the latched word
    assign cmd         = sr_q[`CMD_HI:`CMD_LO];
    assign is_on_off   = cmd == serial_switch_pkg::CMD_ON_OFF;
    assign is_open_en  = cmd == serial_switch_pkg::CMD_OPEN_EN;
    assign is_soft_rst = cmd == serial_switch_pkg::CMD_SOFT_RST;

    // Control latches taken at chip select rise
    always_ff @(posedge clk) begin
        if (clr || (cs_rise && is_soft_rst)) begin
            ctrl_q      <= '0;
            open_cur_en <= '0;
        end else if (cs_rise) begin
            if (is_on_off) begin
                ctrl_q <= sr_q[N_OUT-1:0];
            end
            if (is_open_en) begin
                open_cur_en <= sr_q[N_OUT-1:0];
            end
        end
    end

    // Whole word handed on for the other command decoders
    always_ff @(posedge clk) begin
        if (clr) begin
            cmd_word   <= '0;
            cmd_strobe <= 1'b0;
        end else begin
            cmd_strobe <= cs_rise;
            if (cs_rise) begin
                cmd_word <= sr_q;
            end
        end
    end

    // Switching latency: outputs follow the latch after the least delay
    always_ff @(posedge clk) begin
        if (clr) begin
            st_q   <= serial_switch_pkg::ST_IDLE;
            wait_q <= '0;
            pend_q <= '0;
            out_on <= '0;
        end else begin
            case (st_q)
                serial_switch_pkg::ST_IDLE: begin
                    if (cs_rise) begin
                        st_q   <= serial_switch_pkg::ST_WAIT;
                        wait_q <= 6'(`SWITCH_CYC - 1);
                    end
                end
                serial_switch_pkg::ST_WAIT: begin
                    if (wait_q == 6'h00) begin
                        st_q   <= serial_switch_pkg::ST_IDLE;
                        out_on <= pend_q;
                    end else begin
                        wait_q <= wait_q - 6'h01;
                    end
                end
                default: begin
                    st_q <= serial_switch_pkg::ST_IDLE;
                end
            endcase
            pend_q <= ctrl_q;
        end
    end

    // Per-output fault filters: short while on, open while off with open current
    genvar i;
    generate
        for (i = 0; i < N_OUT; i = i + 1) begin : g_flt
            fault_filter #(
                .COUNT (`FAULT_CYC)
            ) u_flt (
                .clk   (clk),
                .reset (clr),
                .raw   ({short_raw[i], open_raw[i]}),
                .qual  ({out_on[i], !out_on[i] && open_cur_en[i]}),
                .fault (fault[i])
            );
        end
    endgenerate

    // Overvoltage flag synchronised, no persistence filter
    fault_filter #(
        .COUNT (1)
    ) u_ov (
        .clk   (clk),
        .reset (clr),
        .raw   ({ov_raw, 1'b0}),
        .qual  (2'h2),
        .fault (ov_fault)
    );

endmodule : serial_switch_spi

/* common/serial_switch_defs.svh */
// Constants for the serial switch control interface
`ifndef SERIAL_SWITCH_DEFS_SVH
`define SERIAL_SWITCH_DEFS_SVH

`define WORD_W          24
`define N_OUT           16
`define CMD_HI          23
`define CMD_LO          18
`define ANY_FAULT_BIT   23
`define OV_FAULT_BIT    22
`define CLK_MHZ         25
// Least fault persistence before a fault bit sets, in microseconds
`define FAULT_MIN_US    100
// Least output switching latency after chip select rises, in nanoseconds
`define SWITCH_MIN_NS   1000
`define FAULT_CYC       (`FAULT_MIN_US * `CLK_MHZ)
`define SWITCH_CYC      ((`SWITCH_MIN_NS * `CLK_MHZ + 999) / 1000)
// Idle levels of the synchronised pins {rst_n, cs_n, sclk, si}: out of reset, deselected, clock low
`define PIN_IDLE        4'hC

`endif

/* common/serial_switch_pkg.sv */
// Types for the serial switch control interface
package serial_switch_pkg;

    typedef enum logic [5:0] {
        CMD_ON_OFF    = 6'h00,
        CMD_OPEN_EN   = 6'h01,
        CMD_RETRY     = 6'h02,
        CMD_SFPD      = 6'h03,
        CMD_PWM_EN    = 6'h04,
        CMD_AND_OR    = 6'h05,
        CMD_SOFT_RST  = 6'h06
    } cmd_e;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } latch_state_e;

endpackage : serial_switch_pkg

/* hdl/fault_filter.sv */
// Synchroniser and persistence timer for one output's fault conditions
`timescale 1ns/1ps
`include "serial_switch_defs.svh"

module fault_filter #(
    parameter int COUNT = `FAULT_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Raw conditions from the output stage: {short, open}
    input  wire logic [1:0] raw,
    // Same-domain qualifiers: {output on, output off with open current}
    input  wire logic [1:0] qual,
    // Filtered fault
    output logic            fault
);

    localparam int CW = $clog2(COUNT + 1);

    logic [1:0]    s1_q;
    logic [1:0]    s2_q;
    logic [1:0]    s3_q;
    logic [1:0]    stab_q;
    logic [CW-1:0] cnt_q;
    logic          hit;
    logic          done;

    generate
        if (COUNT < 1) begin : g_chk
            $error("fault_filter: COUNT must be at least 1");
        end
    endgenerate

    // Three-stage synchroniser; a change counts when stages two and three agree
    always_ff @(posedge clk) begin
        s1_q <= raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stab_q <= 2'h0;
        end else begin
            stab_q <= (s2_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
        end
    end

    // Qualified condition and terminal count
    assign hit  = |(stab_q & qual);
    assign done = (cnt_q == CW'(COUNT));

    // Persistence counter saturates at the least fault time
    always_ff @(posedge clk) begin
        if (reset || !hit) begin
            cnt_q <= '0;
        end else if (!done) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fault <= 1'b0;
        end else begin
            fault <= hit && done;
        end
    end

endmodule : fault_filter

/* tb/serial_switch_spi_chk.sv */
// Port checks for the serial switch interface
`timescale 1ns/1ps
module serial_switch_spi_chk #(
    parameter int WORD_W = 24,
    parameter int N_OUT  = 16
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // Pins
    input wire logic              rst_pin_n,
    input wire logic              cs_n,
    input wire logic              so_oe,
    // Outputs and command word
    input wire logic [N_OUT-1:0]  out_on,
    input wire logic [N_OUT-1:0]  open_cur_en,
    input wire logic [WORD_W-1:0] cmd_word,
    input wire logic              cmd_strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Steady selection, steady deselection, end of a latched command
    sequence sel_s; (!cs_n && rst_pin_n)[*7]; endsequence
    sequence idle_s; cs_n[*5]; endsequence
    sequence word_s(c); $fell(cmd_strobe) && cmd_word[23:18] == c; endsequence

    oe_sel_a: assert property (sel_s |-> so_oe)
        else $error("so not driven while selected");
    oe_idle_a: assert property (idle_s |-> !so_oe)
        else $error("so driven while deselected");
    strobe_after_a: assert property ($rose(cs_n) && rst_pin_n |-> ##[2:7] cmd_strobe)
        else $error("no command strobe after select rise");
    strobe_pulse_a: assert property (cmd_strobe |-> cs_n ##1 !cmd_strobe)
        else $error("strobe while selected or too long");
    word_hold_a: assert property ($changed(cmd_word) && rst_pin_n |-> $past(cmd_strobe) || cmd_strobe)
        else $error("command word changed without strobe");
    out_follow_a: assert property (word_s(6'h00) |-> ##[20:40] out_on == cmd_word[N_OUT-1:0])
        else $error("outputs did not follow on/off word");
    out_early_a: assert property ($fell(cmd_strobe) |-> $stable(out_on)[*8])
        else $error("outputs switched too early");
    open_follow_a: assert property (word_s(6'h01) |-> ##[0:40] open_cur_en == cmd_word[N_OUT-1:0])
        else $error("open enables did not follow word");
    pin_reset_a: assert property ((!rst_pin_n)[*6] |-> out_on == '0 && cmd_word == '0 && !so_oe)
        else $error("reset pin did not clear state");
endmodule : serial_switch_spi_chk

bind serial_switch_spi serial_switch_spi_chk #(.WORD_W(WORD_W), .N_OUT(N_OUT)) chk (
    .clk(clk), .reset(reset), .rst_pin_n(rst_pin_n), .cs_n(cs_n), .so_oe(so_oe),
    .out_on(out_on), .open_cur_en(open_cur_en), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe));

/* tb/spi_master_model.sv */
// Master model of the serial switch link
`timescale 1ns/1ps
module spi_master_model (
    // Pin timing clock
    input wire logic clk,
    // Link pins
    output logic     cs_n,
    output logic     sclk,
    output logic     si,
    input wire logic so
);
    // Idle: deselected, clock low, data at its pull-down level
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end

    // Wait falling clock edges
    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask : gap

    // One frame, first entry first; 4 clk high and 8 clk low is about 2.08 MHz
    task automatic xfer(input logic d[$], output logic r[$]);
        r = {};
        cs_n = 1'b0;
        gap(6);
        foreach (d[i]) begin
            si = d[i];
            gap(4);
            sclk = 1'b1;
            gap(4);
            sclk = 1'b0;
            gap(4);
            r.push_back(so);
        end
        gap(2);
        cs_n = 1'b1;
        si = 1'b0;
    endtask : xfer

    // Toggle clock and data while deselected
    task automatic noise(input int n);
        repeat (n) begin
            si = ~si;
            sclk = 1'b1;
            gap(4);
            sclk = 1'b0;
            gap(4);
        end
    endtask : noise
endmodule : spi_master_model

/* tb/serial_switch_spi_tb.sv */
// Self-checking bench for the serial switch interface
`timescale 1ns/1ps
module serial_switch_spi_tb;
    // Row: word sent, outputs and open enables expected
    typedef struct packed {
        logic [23:0] w;
        logic [15:0] on;
        logic [15:0] oc;
    } row_s;
    localparam row_s rows [8] = '{
        '{24'h00_A5C3, 16'hA5C3, 16'h0000}, '{24'h04_00FF, 16'hA5C3, 16'h00FF},
        '{24'h08_1234, 16'hA5C3, 16'h00FF}, '{24'h0C_FFFF, 16'hA5C3, 16'h00FF},
        '{24'h10_FFFF, 16'hA5C3, 16'h00FF}, '{24'h14_FFFF, 16'hA5C3, 16'h00FF},
        '{24'h18_0000, 16'h0000, 16'h0000}, '{24'h00_8001, 16'h8001, 16'h0000}};
    logic        clk, reset, rst_pin_n, so_o, so_oe, cmd_strobe, ov_raw;
    wire logic   cs_n, sclk, si;
    logic [15:0] out_on, open_cur_en, short_raw, open_raw;
    logic [23:0] cmd_word;
    logic        tx[$], rx[$];
    int          failures, n_checks;
    wire logic   so = so_oe ? so_o : 1'bz;

    // Device and master
    serial_switch_spi dut (.clk(clk), .reset(reset), .rst_pin_n(rst_pin_n), .cs_n(cs_n),
        .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe), .out_on(out_on),
        .open_cur_en(open_cur_en), .short_raw(short_raw), .open_raw(open_raw),
        .ov_raw(ov_raw), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe));
    spi_master_model m (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));

    // Compare and count
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Word from received bits at k, first bit most significant
    function automatic logic [23:0] take(input int k);
        logic [23:0] v;
        for (int i = 0; i < 24; i++) v[23-i] = rx[k+i];
        return v;
    endfunction : take
    // Queue a word, most significant bit first
    task automatic push(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) tx.push_back(w[i]);
    endtask : push
    // Send the queued frame, let outputs settle
    task automatic send();
        m.xfer(tx, rx);
        tx = {};
        m.gap(60);
    endtask : send
    // Counts and verdict
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Main sequence
    initial begin
        failures = 0;
        n_checks = 0;
        reset = 1'b1;
        rst_pin_n = 1'b1;
        short_raw = '0;
        open_raw = '0;
        ov_raw = 1'b0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        m.gap(6);
        check(24'(out_on), 24'h0);
        foreach (rows[i]) begin
            push(rows[i].w);
            send();
            check(take(0), 24'h0);
            check(cmd_word, rows[i].w);
            check(24'(out_on), 24'(rows[i].on));
            check(24'(open_cur_en), 24'(rows[i].oc));
            check(24'(so_oe), 24'h0);
        end
        // Shorts on two driven outputs and an idle one, opens on an enabled and a disabled output
        push(24'h04_0002);
        send();
        short_raw = 16'h8009;
        open_raw = 16'h0006;
        m.gap(1200);
        push(24'h04_0002);
        send();
        check(take(0), 24'h0);
        m.gap(11300);
        push(24'h04_0002);
        send();
        check(take(0), 24'h80_8003);
        ov_raw = 1'b1;
        m.gap(20);
        push(24'h04_0002);
        send();
        check(take(0), 24'hC0_8003);
        ov_raw = 1'b0;
        short_raw = '0;
        open_raw = '0;
        // Two words: the first comes back behind the status
        push(24'h00_0F0F);
        push(24'h00_00F0);
        send();
        check(take(24), 24'h00_0F0F);
        check(24'(out_on), 24'h00F0);
        // Thirty bits: the last 24 act
        repeat (6) tx.push_back(1'b1);
        push(24'h00_3C3C);
        send();
        check(24'(out_on), 24'h3C3C);
        // Clocking while deselected, then twelve bits land behind the low half of the status
        m.noise(8);
        check(cmd_word, 24'h00_3C3C);
        repeat (12) tx.push_back(1'b1);
        send();
        check(cmd_word, 24'h00_0FFF);
        check(24'(out_on), 24'h0FFF);
        // Reset pin
        rst_pin_n = 1'b0;
        m.gap(10);
        check(24'(out_on), 24'h0);
        check(cmd_word, 24'h0);
        check(24'(open_cur_en), 24'h0);
        rst_pin_n = 1'b1;
        m.gap(10);
        tally_and_finish();
    end
endmodule : serial_switch_spi_tb
